//--- hw/dib_top.sv
// 48-channel discrete input bank with front-panel fault indicator
//
// What this block does
// - capture the on/off state of all 48 isolated inputs into readable buffers
// - first field connector inputs land on channels 1 to 24
// - second field connector inputs land on channels 25 to 48
// - channels numbered in sequence; channel n is buffer bit n-1
// - red fault indicator is lit whenever the system reset is applied
// - processor clears indicator once application runs and board seen; device obeys
`timescale 1ns/1ns
`include "dib_defines.svh"

module dib_top
  import dib_pkg::*;
(
  // clock and reset
  input  wire logic                     clk_i,
  input  wire logic                     rst_b_i,
  // field contacts after isolation, 1 means closed
  input  wire logic [`DIB_HALF_CH-1:0]  conn1_contact_i,
  input  wire logic [`DIB_HALF_CH-1:0]  conn2_contact_i,
  // processor side strobes
  input  wire logic                     fault_on_i,
  input  wire logic                     fault_clear_i,
  input  wire logic                     rd_stb_i,
  // processor side results
  output logic      [`DIB_NUM_CH-1:0]   ch_state_o,
  output logic      [`DIB_NUM_CH-1:0]   rd_data_o,
  output logic                          rd_valid_o,
  output logic                          board_present_o,
  // front panel
  output logic                          fault_led_o
);

  // reset release through two flops; assertion still acts at once
  logic rst_s1_q;
  logic rst_s1_d;
  logic rst_s2_q;
  logic rst_s2_d;
  logic rst_b;

  // a high shifts in once the pin lets go, so release lands on a clean edge
  always_comb
  begin
    rst_s1_d = 1'b1;
    rst_s2_d = rst_s1_q;
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end
    else
    begin
      rst_s1_q <= rst_s1_d;
      rst_s2_q <= rst_s2_d;
    end
  end

  assign rst_b = rst_s2_q;

  // channel placement: second connector above the first
  logic [`DIB_NUM_CH-1:0] field_raw;
  logic [`DIB_NUM_CH-1:0] field_sync;

  assign field_raw = {conn2_contact_i, conn1_contact_i};

  dib_sync u_sync
  (
    .clk_i   (clk_i),
    .rst_b_i (rst_b),
    .async_i (field_raw),
    .sync_o  (field_sync)
  );

  // live input buffer, refreshed every cycle
  logic [`DIB_NUM_CH-1:0] buf_q;
  logic [`DIB_NUM_CH-1:0] buf_d;

  always_comb
  begin
    buf_d = field_sync;
  end

  always_ff @(posedge clk_i or negedge rst_b)
  begin
    if (!rst_b)
    begin
      buf_q <= `DIB_BUF_RESET;
    end
    else
    begin
      buf_q <= buf_d;
    end
  end

  // read snapshot, held so a multi-beat reader sees one coherent sample
  logic [`DIB_NUM_CH-1:0] rd_q;
  logic [`DIB_NUM_CH-1:0] rd_d;
  logic                   rd_vld_q;
  logic                   rd_vld_d;

  // copies the registered buffer, not the synchroniser, so the word matches ch_state_o
  always_comb
  begin
    rd_d     = rd_q;
    rd_vld_d = 1'b0;
    if (rd_stb_i)
    begin
      rd_d     = buf_q;
      rd_vld_d = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rd_q     <= `DIB_BUF_RESET;
      rd_vld_q <= 1'b0;
    end
    else
    begin
      rd_q     <= rd_d;
      rd_vld_q <= rd_vld_d;
    end
  end

  // fault indicator state
  dib_fault_st_t flt_q;
  dib_fault_st_t flt_d;

  always_comb
  begin
    flt_d = flt_q;
    case (flt_q)
      DIB_FLT_RESET,
      DIB_FLT_INIT:
      begin
        // turn-on beats a clear in the same cycle so the lamp never drops early
        if (fault_on_i)
        begin
          flt_d = DIB_FLT_INIT;
        end
        else if (fault_clear_i)
        begin
          flt_d = DIB_FLT_RUN;
        end
      end
      DIB_FLT_RUN:
      begin
        if (fault_on_i)
        begin
          flt_d = DIB_FLT_INIT;
        end
      end
      default:
      begin
        flt_d = DIB_FLT_RESET;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_b)
  begin
    if (!rst_b)
    begin
      flt_q <= DIB_FLT_RESET;
    end
    else
    begin
      flt_q <= flt_d;
    end
  end

  // lamp taken from the next state so it moves on the command edge, not one later
  logic led_q;
  logic led_d;

  always_comb
  begin
    led_d = (flt_d != DIB_FLT_RUN);
  end

  always_ff @(posedge clk_i or negedge rst_b)
  begin
    if (!rst_b)
    begin
      led_q <= `DIB_LED_RESET;
    end
    else
    begin
      led_q <= led_d;
    end
  end

  // presence flag answers the processor's board check once out of reset
  logic pres_q;
  logic pres_d;

  always_comb
  begin
    pres_d = `DIB_PRESENT_VAL;
  end

  always_ff @(posedge clk_i or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pres_q <= 1'b0;
    end
    else
    begin
      pres_q <= pres_d;
    end
  end

  assign ch_state_o      = buf_q;
  assign rd_data_o       = rd_q;
  assign rd_valid_o      = rd_vld_q;
  assign board_present_o = pres_q;
  assign fault_led_o     = led_q;

endmodule : dib_top

//--- include/dib_defines.svh
// constants for the 48-channel discrete input bank
`ifndef DIB_DEFINES_SVH
`define DIB_DEFINES_SVH

`define DIB_NUM_CH      48
`define DIB_HALF_CH     24
`define DIB_LED_RESET   1'b1
`define DIB_PRESENT_VAL 1'b1
`define DIB_BUF_RESET   48'h0000_0000_0000

`endif

//--- include/dib_pkg.sv
// types for the 48-channel discrete input bank
package dib_pkg;

  typedef enum logic [1:0] {
    DIB_FLT_RESET,
    DIB_FLT_INIT,
    DIB_FLT_RUN
  } dib_fault_st_t;

endpackage : dib_pkg

//--- hw/dib_sync.sv
// two-flop synchroniser for the field contact inputs
`timescale 1ns/1ns
`include "dib_defines.svh"

module dib_sync
(
  // clock and reset
  input  wire logic                    clk_i,
  input  wire logic                    rst_b_i,
  // asynchronous in, synchronous out
  input  wire logic [`DIB_NUM_CH-1:0]  async_i,
  output logic      [`DIB_NUM_CH-1:0]  sync_o
);

  genvar gi;
  generate
    for (gi = 0; gi < `DIB_NUM_CH; gi = gi + 1)
    begin : g_bit
      logic meta_q;
      logic meta_d;
      logic hold_q;
      logic hold_d;

      // first stage is read only by the second stage
      always_comb
      begin
        meta_d = async_i[gi];
        hold_d = meta_q;
      end

      always_ff @(posedge clk_i or negedge rst_b_i)
      begin
        if (!rst_b_i)
        begin
          meta_q <= 1'b0;
          hold_q <= 1'b0;
        end
        else
        begin
          meta_q <= meta_d;
          hold_q <= hold_d;
        end
      end

      assign sync_o[gi] = hold_q;
    end
  endgenerate

endmodule : dib_sync

//--- tb/dib_props.sv
// port assertions for the input bank
`timescale 1ns/1ns
module dib_props (
  input wire logic        clk_i, rst_b_i, fault_on_i, fault_clear_i, rd_stb_i,
  input wire logic        rd_valid_o, board_present_o, fault_led_o,
  input wire logic [23:0] conn1_contact_i, conn2_contact_i,
  input wire logic [47:0] ch_state_o, rd_data_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  // skip two cycles after reset while the synchroniser still holds its cleared value
  a_low_half: assert property
    (board_present_o && $past(board_present_o, 2)
      |-> ch_state_o[23:0] == $past(conn1_contact_i, 3)) else $error("low");
  a_high_half: assert property
    (board_present_o && $past(board_present_o, 2)
      |-> ch_state_o[47:24] == $past(conn2_contact_i, 3)) else $error("high");
  a_read_snap: assert property
    (rd_stb_i |=> rd_valid_o && rd_data_o == $past(ch_state_o)) else $error("snap");
  a_valid_pulse: assert property
    (!rd_stb_i |=> !rd_valid_o) else $error("valid");
  a_read_hold: assert property
    (!rd_stb_i |=> $stable(rd_data_o)) else $error("hold");
  a_led_reset: assert property
    ($rose(rst_b_i) |-> fault_led_o) else $error("led reset");
  a_led_clear: assert property
    (fault_clear_i && !fault_on_i |=> !fault_led_o) else $error("clear");
  a_led_hold: assert property
    (!fault_on_i && !fault_clear_i |=> $stable(fault_led_o)) else $error("led");
endmodule : dib_props
bind dib_top dib_props props (
  .clk_i           (clk_i),
  .rst_b_i         (rst_b_i),
  .fault_on_i      (fault_on_i),
  .fault_clear_i   (fault_clear_i),
  .rd_stb_i        (rd_stb_i),
  .rd_valid_o      (rd_valid_o),
  .board_present_o (board_present_o),
  .fault_led_o     (fault_led_o),
  .conn1_contact_i (conn1_contact_i),
  .conn2_contact_i (conn2_contact_i),
  .ch_state_o      (ch_state_o),
  .rd_data_o       (rd_data_o)
);

//--- tb/dib_cpu_model.sv
// processor side: fault indicator handling
`timescale 1ns/1ns
module dib_cpu_model (
  input  wire logic clk_i, run_i, present_i,
  output logic      on_o = 1'b1, clr_o = 1'b0
);
  // initialising while application not running
  always @(posedge clk_i)
  begin
    on_o  <= !run_i;
    clr_o <= run_i && present_i && on_o;
  end
endmodule : dib_cpu_model

//--- tb/dib_top_test.sv
// testbench for the input bank
`timescale 1ns/1ns
`define CK(n, e, g) begin n_compared++; if ((g) !== (e)) begin num_errors++; \
  $display("unexpected %s exp %h got %h", n, e, g); end end
module dib_top_test;
  logic        clk_i = 0, rst_b_i = 0, run = 0, rd_stb_i = 0, on_w, clr_w, rv, bp, led;
  logic [23:0] c1 = 0, c2 = 0;
  logic [47:0] ch, rd, v;
  int          num_errors = 0, n_compared = 0;
  always #5 clk_i = ~clk_i;
  dib_top DUT (.clk_i, .rst_b_i, .conn1_contact_i(c1), .conn2_contact_i(c2),
    .fault_on_i(on_w), .fault_clear_i(clr_w), .rd_stb_i, .ch_state_o(ch),
    .rd_data_o(rd), .rd_valid_o(rv), .board_present_o(bp), .fault_led_o(led));
  dib_cpu_model cpu (.clk_i, .run_i(run), .present_i(bp), .on_o(on_w), .clr_o(clr_w));
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : cyc
  task automatic t_led;
    cyc(5);
    `CK("led", 1'b1, led)
    `CK("present", 1'b1, bp)
    @(posedge clk_i) run <= 1'b1;
    cyc(3);
    `CK("led", 1'b0, led)
    @(posedge clk_i) run <= 1'b0;
    cyc(2);
    `CK("led", 1'b1, led)
    @(posedge clk_i) run <= 1'b1;
    cyc(3);
    `CK("led", 1'b0, led)
    $display("led test done");
  endtask : t_led
  task automatic t_map;
    for (int i = 0; i < 48; i++)
    begin
      @(posedge clk_i) {c2, c1} <= 48'h1 << i;
      cyc(3);
      `CK("ch", 48'h1 << i, ch)
    end
    $display("map test done");
  endtask : t_map
  task automatic t_read;
    v = 48'hA5C3_0F96_E187;
    @(posedge clk_i) {c2, c1} <= v;
    cyc(3);
    // strobe held two edges: back-to-back reads
    @(posedge clk_i) rd_stb_i <= 1'b1;
    @(posedge clk_i) {c2, c1} <= ~v;
    #1 `CK("valid", 1'b1, rv)
    `CK("rd", v, rd)
    @(posedge clk_i) rd_stb_i <= 1'b0;
    cyc(3);
    `CK("valid", 1'b0, rv)
    `CK("rd", v, rd)
    @(posedge clk_i) rd_stb_i <= 1'b1;
    @(posedge clk_i) rd_stb_i <= 1'b0;
    #1 `CK("rd", ~v, rd)
    $display("read test done");
  endtask : t_read
  task automatic t_reset;
    // mid-run reset with contacts closed: lamp relights, buffers clear, inputs return
    @(posedge clk_i) rst_b_i <= 1'b0;
    run <= 1'b0;
    #1 `CK("led", 1'b1, led)
    `CK("ch", 48'h0, ch)
    `CK("rd", 48'h0, rd)
    `CK("present", 1'b0, bp)
    cyc(3);
    @(posedge clk_i) rst_b_i <= 1'b1;
    cyc(2);
    `CK("led", 1'b1, led)
    cyc(5);
    `CK("ch", ~v, ch)
    `CK("present", 1'b1, bp)
    @(posedge clk_i) run <= 1'b1;
    cyc(3);
    `CK("led", 1'b0, led)
    $display("reset test done");
  endtask : t_reset
  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : complete_run
  initial
  begin
    #10000;
    num_errors++;
    complete_run();
  end
  initial
  begin
    cyc(11);
    `CK("led", 1'b1, led)
    `CK("present", 1'b0, bp)
    @(posedge clk_i) rst_b_i <= 1'b1;
    t_led();
    t_map();
    t_read();
    t_reset();
    complete_run();
  end
endmodule : dib_top_test
